/* logic/usb_ep_ctrl_pkg.sv */
// package for the endpoint transmit control block: register map, fields, reset values, codes
// assumes a 32-bit AXI4-Lite register bus; offsets are byte addresses of aligned words
package usb_ep_ctrl_pkg;
  // printed offsets are not all multiples of four, so they are indices; byte address is index times four
  localparam logic [7:0] CTRL_TX_CONTROL_IDX = 8'hEA;
  localparam logic [7:0] SHARED_TX_CONTROL_IDX = 8'hEB;
  localparam logic [7:0] ENDPOINT_ENABLE_IDX = 8'hEC;
  localparam logic [7:0] FLAG_STATUS_IDX = 8'hE8;
  localparam logic [7:0] CTRL_TX_DATA_IDX = 8'hE7;
  localparam logic [7:0] SHARED_TX_DATA_IDX = 8'hE6;
  localparam logic [11:0] CTRL_TX_CONTROL_ADDR = {2'h0, CTRL_TX_CONTROL_IDX, 2'h0};
  localparam logic [11:0] SHARED_TX_CONTROL_ADDR = {2'h0, SHARED_TX_CONTROL_IDX, 2'h0};
  localparam logic [11:0] ENDPOINT_ENABLE_ADDR = {2'h0, ENDPOINT_ENABLE_IDX, 2'h0};
  localparam logic [11:0] FLAG_STATUS_ADDR = {2'h0, FLAG_STATUS_IDX, 2'h0};
  localparam logic [11:0] CTRL_TX_DATA_ADDR = {2'h0, CTRL_TX_DATA_IDX, 2'h0};
  localparam logic [11:0] SHARED_TX_DATA_ADDR = {2'h0, SHARED_TX_DATA_IDX, 2'h0};
  // field positions in the two transmit control registers
  localparam int SEQ_BIT = 7;
  localparam int STALL_BIT = 6;
  localparam int SEL_BIT = 6;
  localparam int TXEN_BIT = 5;
  localparam int RXEN_BIT = 4;
  localparam int RESUME_BIT = 4;
  // field positions in the flag status register
  localparam int CTRL_TXD_BIT = 4;
  localparam int CTRL_RXD_BIT = 3;
  localparam int SHARED_TXD_BIT = 2;
  localparam int RESUMED_BIT = 0;
  // field positions in the endpoint enable register
  localparam int EP2_EN_BIT = 3;
  localparam int EP1_EN_BIT = 2;
  localparam int EP2_STALL_BIT = 1;
  localparam int EP1_STALL_BIT = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] ENABLE_REG_MASK = 8'h0F;
  localparam logic [7:0] SHARED_CTRL_WMASK = 8'hFF;
  localparam int BUF_DEPTH = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // token and handshake codes on the token port
  typedef enum logic [1:0] {TOK_OUT = 2'h0, TOK_IN = 2'h1, TOK_SETUP = 2'h2, TOK_SOF = 2'h3} token_type;
  typedef enum logic [1:0] {ANS_NAK = 2'h0, ANS_STALL = 2'h1, ANS_DATA = 2'h2, ANS_ACCEPT = 2'h3} answer_type;
  localparam logic [3:0] PID_DATA0 = 4'h3;
  localparam logic [3:0] PID_DATA1 = 4'hB;
endpackage

/* logic/token_answer.sv */
// decides the answer to one token for one endpoint from stall, enable, done and select state
// assumes all inputs come from registers on sys_clk
`timescale 1ns/1ps
`default_nettype none
module token_answer
  import usb_ep_ctrl_pkg::*;
(
  input wire logic isIn,
  input wire logic stalled,
  input wire logic enabled,
  input wire logic doneFlag,
  input wire logic selOk,
  output answer_type answer
);
  // stall wins over everything, then nak on any missing condition
  assign answer = stalled ? ANS_STALL :                                    // RL2 RL21
    (!enabled || doneFlag || !selOk) ? ANS_NAK :                           // RL4 RL6 RL11 RL12
    (isIn ? ANS_DATA : ANS_ACCEPT);
endmodule
`default_nettype wire

/* logic/usb_endpoint_tx_control.sv */
// endpoint transmit and receive control for a low-speed usb function, with AXI4-Lite registers
// assumes the packet engine presents decoded tokens and ack events on sys_clk, one cycle pulses
// Notes on behaviour
// [RL1] control IN pid follows sequence bit, software toggles
// [RL2] control stall bit answers IN/OUT with STALL
// [RL3] hardware clears control stall on SETUP token
// [RL4] control IN NAKs if disabled or done set
// [RL5] software sets/clears control transmit enable
// [RL6] control OUT NAKs if disabled or done set
// [RL7] software sets/clears control receive enable
// [RL8] four-bit byte count in bits 3..0
// [RL9] shared IN pid follows shared sequence bit
// [RL10] select bit gives buffer to endpoint 1/2
// [RL11] endpoint 2 IN NAKs when select points at 1
// [RL12] shared IN NAKs if disabled or done set
// [RL13] software enables endpoint, then shared transmit
// [RL14] force resume drives K onto lines
// [RL15] software holds resume 10 to 15 ms
// [RL16] own resume never sets resume-detected flag
// [RL17] reset clears both transmit control registers
// [RL18] control tx done set only after ACK
// [RL19] control rx done set after received ACKed packet
// [RL20] send exactly byte-count bytes from matching buffer
// [RL21] stall wins over NAK and data
`timescale 1ns/1ps
`default_nettype none
module usb_endpoint_tx_control
  import usb_ep_ctrl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tokenValid,
  input wire token_type tokenKind,
  input wire logic [3:0] tokenEndpoint,
  output answer_type tokenAnswer,
  output logic [3:0] txPid,
  output logic [3:0] txByteCount,
  input wire logic txByteReq,
  output logic [7:0] txByte,
  output logic txLast,
  input wire logic hostAck,
  input wire logic rxPacketAcked,
  input wire logic busActivity,
  input wire logic suspended,
  output logic resumeDriveK,
  output logic resumeDriveEn
);
  logic [7:0] ctrlTxControl_r;
  logic [7:0] sharedTxControl_r;
  logic [7:0] enableReg_r;
  logic ctrlTxDone_r, ctrlRxDone_r, sharedTxDone_r, resumeDetected_r;
  logic [7:0] ctrlBuf [BUF_DEPTH];
  logic [7:0] sharedBuf [BUF_DEPTH];
  logic [2:0] ctrlWrPtr_r, sharedWrPtr_r, rdPtr_r;
  logic [3:0] sentCount_r;
  logic pendIn_r, pendCtrl_r, inFlight_r;
  logic awHeld_r, wHeld_r, bvalid_r, rvalid_r;
  logic [11:0] awAddr_r;
  logic [31:0] wData_r, rData_r;
  logic [3:0] wStrb_r;
  logic [1:0] rResp_r, bResp_r;
  logic actSync1_r, actSync2_r;

  // address decode shared by read and write
  function automatic logic known_addr(input logic [11:0] a);
    return a == CTRL_TX_CONTROL_ADDR || a == SHARED_TX_CONTROL_ADDR || a == ENDPOINT_ENABLE_ADDR ||
      a == FLAG_STATUS_ADDR || a == CTRL_TX_DATA_ADDR || a == SHARED_TX_DATA_ADDR;
  endfunction

  // write channel capture: address and data taken in either order
  wire doWrite = awHeld_r && wHeld_r && !bvalid_r;
  wire wrLane0 = doWrite && wStrb_r[0];
  wire wrCtrlCtl = wrLane0 && awAddr_r == CTRL_TX_CONTROL_ADDR;
  wire wrSharedCtl = wrLane0 && awAddr_r == SHARED_TX_CONTROL_ADDR;
  wire wrEnable = wrLane0 && awAddr_r == ENDPOINT_ENABLE_ADDR;
  wire wrFlags = wrLane0 && awAddr_r == FLAG_STATUS_ADDR;
  wire wrCtrlData = wrLane0 && awAddr_r == CTRL_TX_DATA_ADDR;
  wire wrSharedData = wrLane0 && awAddr_r == SHARED_TX_DATA_ADDR;
  assign s_axi_awready = !awHeld_r && clkEn; // no capture while frozen
  assign s_axi_wready = !wHeld_r && clkEn;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bResp_r;
  assign s_axi_arready = !rvalid_r && clkEn;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;

  // read data selection
  wire [7:0] flagByte = {3'h0, ctrlTxDone_r, ctrlRxDone_r, sharedTxDone_r, 1'b0, resumeDetected_r};
  wire [7:0] readByte = s_axi_araddr == CTRL_TX_CONTROL_ADDR ? ctrlTxControl_r :
    s_axi_araddr == SHARED_TX_CONTROL_ADDR ? sharedTxControl_r :
    s_axi_araddr == ENDPOINT_ENABLE_ADDR ? enableReg_r :
    s_axi_araddr == FLAG_STATUS_ADDR ? flagByte : 8'h00;

  // bus slave state
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      bvalid_r <= 1'b0;
      bResp_r <= RESP_OKAY;
      awAddr_r <= 12'h000;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      rvalid_r <= 1'b0;
      rData_r <= 32'h0000_0000;
      rResp_r <= RESP_OKAY;
    end else if (clkEn) begin
      if (s_axi_awvalid && !awHeld_r) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHeld_r) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite) begin
        bvalid_r <= 1'b1;
        bResp_r <= known_addr(awAddr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
      end
      if (s_axi_arvalid && !rvalid_r) begin
        rvalid_r <= 1'b1;
        rData_r <= {24'h00_0000, readByte};
        rResp_r <= known_addr(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // token decode and answer
  wire isCtrlEp = tokenEndpoint == 4'h0;
  wire isEp1 = tokenEndpoint == 4'h1;
  wire isEp2 = tokenEndpoint == 4'h2;
  wire isIn = tokenKind == TOK_IN;
  wire isData = tokenKind == TOK_IN || tokenKind == TOK_OUT;
  wire setupCtrl = tokenValid && tokenKind == TOK_SETUP && isCtrlEp;
  wire ctrlEnable = isIn ? ctrlTxControl_r[TXEN_BIT] : ctrlTxControl_r[RXEN_BIT];
  wire ctrlDone = isIn ? ctrlTxDone_r : ctrlRxDone_r;
  wire sharedStall = isEp2 ? enableReg_r[EP2_STALL_BIT] : enableReg_r[EP1_STALL_BIT];
  wire sharedEpOn = isEp2 ? enableReg_r[EP2_EN_BIT] : enableReg_r[EP1_EN_BIT];
  wire selOk = sharedTxControl_r[SEL_BIT] == isEp2; // RL10 RL11
  wire sharedSelOk = sharedEpOn && isIn && selOk;
  answer_type ctrlAnswer, sharedAnswer;
  token_answer ctrlDecide (
    .isIn(isIn), .stalled(ctrlTxControl_r[STALL_BIT]), .enabled(ctrlEnable),
    .doneFlag(ctrlDone), .selOk(1'b1), .answer(ctrlAnswer)
  );
  token_answer sharedDecide (
    .isIn(isIn), .stalled(sharedStall), .enabled(sharedTxControl_r[TXEN_BIT]),
    .doneFlag(sharedTxDone_r), .selOk(sharedSelOk), .answer(sharedAnswer)
  );
  assign tokenAnswer = !isData ? ANS_NAK : isCtrlEp ? ctrlAnswer :
    (isEp1 || isEp2) ? sharedAnswer : ANS_NAK;
  wire startIn = tokenValid && isIn && tokenAnswer == ANS_DATA && !inFlight_r;

  // packet parameters for the accepted IN token
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      txPid <= PID_DATA0;
      txByteCount <= 4'h0;
      pendCtrl_r <= 1'b0;
      inFlight_r <= 1'b0;
    end else if (clkEn) begin
      if (startIn) begin
        pendCtrl_r <= isCtrlEp;
        inFlight_r <= 1'b1;
        if (isCtrlEp) begin
          txPid <= ctrlTxControl_r[SEQ_BIT] ? PID_DATA1 : PID_DATA0; // RL1
          txByteCount <= ctrlTxControl_r[3:0]; // RL20
        end else begin
          txPid <= sharedTxControl_r[SEQ_BIT] ? PID_DATA1 : PID_DATA0; // RL9
          txByteCount <= sharedTxControl_r[3:0]; // RL20
        end
      end else if (hostAck || (tokenValid && !startIn)) begin
        inFlight_r <= 1'b0;
      end
    end
  end

  // byte streaming from the matching buffer
  assign txLast = inFlight_r && (sentCount_r + 4'h1 >= txByteCount);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdPtr_r <= 3'h0;
      sentCount_r <= 4'h0;
      txByte <= 8'h00;
      pendIn_r <= 1'b0;
    end else if (clkEn) begin
      pendIn_r <= startIn;
      if (startIn) begin
        rdPtr_r <= 3'h0;
        sentCount_r <= 4'h0;
      end else if (txByteReq && inFlight_r && sentCount_r < txByteCount) begin
        txByte <= pendCtrl_r ? ctrlBuf[rdPtr_r] : sharedBuf[rdPtr_r]; // RL20
        rdPtr_r <= rdPtr_r + 3'h1;
        sentCount_r <= sentCount_r + 4'h1;
      end
    end
  end

  // transmit buffers filled by software writes
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrlWrPtr_r <= 3'h0;
      sharedWrPtr_r <= 3'h0;
    end else if (clkEn) begin
      if (wrCtrlData) begin
        ctrlBuf[ctrlWrPtr_r] <= wData_r[7:0];
        ctrlWrPtr_r <= ctrlWrPtr_r + 3'h1;
      end else if (wrCtrlCtl || (startIn && isCtrlEp)) begin
        ctrlWrPtr_r <= 3'h0;
      end
      if (wrSharedData) begin
        sharedBuf[sharedWrPtr_r] <= wData_r[7:0];
        sharedWrPtr_r <= sharedWrPtr_r + 3'h1;
      end else if (wrSharedCtl || (startIn && !isCtrlEp)) begin
        sharedWrPtr_r <= 3'h0;
      end
    end
  end

  // control registers; setup clears the control stall after any software write
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrlTxControl_r <= REG_RESET; // RL17
      sharedTxControl_r <= REG_RESET; // RL17
      enableReg_r <= REG_RESET;
    end else if (clkEn) begin
      if (wrCtrlCtl) begin
        ctrlTxControl_r <= wData_r[7:0]; // RL8
      end
      if (setupCtrl) begin
        ctrlTxControl_r[STALL_BIT] <= 1'b0; // RL3
      end
      if (wrSharedCtl) begin
        sharedTxControl_r <= wData_r[7:0] & SHARED_CTRL_WMASK; // RL8
      end
      if (wrEnable) begin
        enableReg_r <= wData_r[7:0] & ENABLE_REG_MASK;
      end
    end
  end

  // done flags: hardware set wins over software write-one-to-clear
  wire ackedCtrlIn = hostAck && inFlight_r && pendCtrl_r;
  wire ackedSharedIn = hostAck && inFlight_r && !pendCtrl_r;
  wire resumeSeen = actSync2_r && suspended && !sharedTxControl_r[RESUME_BIT];
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrlTxDone_r <= 1'b0;
      ctrlRxDone_r <= 1'b0;
      sharedTxDone_r <= 1'b0;
      resumeDetected_r <= 1'b0;
    end else if (clkEn) begin
      ctrlTxDone_r <= ackedCtrlIn || (ctrlTxDone_r && !(wrFlags && wData_r[CTRL_TXD_BIT])); // RL18
      ctrlRxDone_r <= rxPacketAcked || (ctrlRxDone_r && !(wrFlags && wData_r[CTRL_RXD_BIT])); // RL19
      sharedTxDone_r <= ackedSharedIn || (sharedTxDone_r && !(wrFlags && wData_r[SHARED_TXD_BIT]));
      resumeDetected_r <= resumeSeen || (resumeDetected_r && !(wrFlags && wData_r[RESUMED_BIT])); // RL16
    end
  end

  // bus activity pin synchroniser
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      actSync1_r <= 1'b0;
      actSync2_r <= 1'b0;
    end else if (clkEn) begin
      actSync1_r <= busActivity;
      actSync2_r <= actSync1_r;
    end
  end

  // forced resume drives the K state
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      resumeDriveK <= 1'b0;
      resumeDriveEn <= 1'b0;
    end else if (clkEn) begin
      resumeDriveK <= sharedTxControl_r[RESUME_BIT]; // RL14
      resumeDriveEn <= sharedTxControl_r[RESUME_BIT]; // RL14
    end
  end

  // checks
  property p_stall_first;
    @(posedge sys_clk) disable iff (!rst_b)
    (tokenValid && isCtrlEp && isData && ctrlTxControl_r[STALL_BIT]) |-> tokenAnswer == ANS_STALL;
  endproperty
  a_stall_first: assert property (p_stall_first) else $error("control stall not answered"); // RL2

  property p_setup_clears;
    @(posedge sys_clk) disable iff (!rst_b)
    (setupCtrl && clkEn) |=> !ctrlTxControl_r[STALL_BIT];
  endproperty
  a_setup_clears: assert property (p_setup_clears) else $error("setup left stall set"); // RL3

  property p_ctrl_in_nak;
    @(posedge sys_clk) disable iff (!rst_b)
    (tokenValid && isCtrlEp && isIn && !ctrlTxControl_r[STALL_BIT] &&
      (!ctrlTxControl_r[TXEN_BIT] || ctrlTxDone_r)) |-> tokenAnswer == ANS_NAK;
  endproperty
  a_ctrl_in_nak: assert property (p_ctrl_in_nak) else $error("control IN not naked"); // RL4

  property p_ctrl_out_nak;
    @(posedge sys_clk) disable iff (!rst_b)
    (tokenValid && isCtrlEp && tokenKind == TOK_OUT && !ctrlTxControl_r[STALL_BIT] &&
      (!ctrlTxControl_r[RXEN_BIT] || ctrlRxDone_r)) |-> tokenAnswer == ANS_NAK;
  endproperty
  a_ctrl_out_nak: assert property (p_ctrl_out_nak) else $error("control OUT not naked"); // RL6

  property p_ep2_sel;
    @(posedge sys_clk) disable iff (!rst_b)
    (tokenValid && isEp2 && isIn && !sharedTxControl_r[SEL_BIT] && !enableReg_r[EP2_STALL_BIT])
      |-> tokenAnswer == ANS_NAK;
  endproperty
  a_ep2_sel: assert property (p_ep2_sel) else $error("endpoint 2 served with wrong buffer"); // RL11

  property p_shared_nak;
    @(posedge sys_clk) disable iff (!rst_b)
    (tokenValid && (isEp1 || isEp2) && isIn && !sharedStall &&
      (!sharedTxControl_r[TXEN_BIT] || sharedTxDone_r)) |-> tokenAnswer == ANS_NAK;
  endproperty
  a_shared_nak: assert property (p_shared_nak) else $error("shared IN not naked"); // RL12

  property p_pid;
    @(posedge sys_clk) disable iff (!rst_b)
    (startIn && clkEn && isCtrlEp) |=> txPid == ($past(ctrlTxControl_r[SEQ_BIT]) ? PID_DATA1 : PID_DATA0);
  endproperty
  a_pid: assert property (p_pid) else $error("control pid mismatch"); // RL1

  property p_txdone_ack;
    @(posedge sys_clk) disable iff (!rst_b)
    $rose(ctrlTxDone_r) |-> $past(hostAck) && $past(pendCtrl_r);
  endproperty
  a_txdone_ack: assert property (p_txdone_ack) else $error("control done without ack"); // RL18

  property p_resume_k;
    @(posedge sys_clk) disable iff (!rst_b)
    (sharedTxControl_r[RESUME_BIT] && clkEn) |=> resumeDriveK && resumeDriveEn;
  endproperty
  a_resume_k: assert property (p_resume_k) else $error("resume K not driven"); // RL14
endmodule
`default_nettype wire

/* bench/usb_host_model.sv */
// host controller stand-in: issues tokens, pulls data bytes, returns handshakes
// assumes callers enter its tasks just after a rising sys_clk edge
`timescale 1ns/1ps
`default_nettype none
module usb_host_model
  import usb_ep_ctrl_pkg::*;
(
  input wire logic sys_clk,
  input wire answer_type tokenAnswer,
  input wire logic [7:0] txByte,
  output var logic tokenValid,
  output var token_type tokenKind,
  output var logic [3:0] tokenEndpoint,
  output var logic txByteReq,
  output var logic hostAck,
  output var logic rxPacketAcked,
  output var logic busActivity,
  output var logic suspended
);
  // quiet bus, no activity, not suspended
  initial begin
    tokenValid = 1'b0;
    tokenKind = TOK_SOF;
    tokenEndpoint = 4'hF;
    txByteReq = 1'b0;
    hostAck = 1'b0;
    rxPacketAcked = 1'b0;
    busActivity = 1'b0;
    suspended = 1'b0;
  end
  // one token pulse; the answer is read mid-cycle while the pulse stands
  task automatic token(input token_type k, input logic [3:0] ep, output answer_type a);
    tokenValid <= 1'b1;
    tokenKind <= k;
    tokenEndpoint <= ep;
    @(negedge sys_clk);
    a = tokenAnswer;
    @(posedge sys_clk);
    tokenValid <= 1'b0;
    tokenKind <= token_type'(~k); // released lines never keep the old code
    tokenEndpoint <= ~ep;
    @(posedge sys_clk);
  endtask
  // ask for one data byte, take it the cycle after the request edge
  task automatic fetch(output logic [7:0] b);
    txByteReq <= 1'b1;
    @(posedge sys_clk);
    txByteReq <= 1'b0;
    @(negedge sys_clk);
    b = txByte;
    @(posedge sys_clk);
  endtask
  // handshake pulse: host ack of our data, or our ack of host data
  task automatic handshake(input logic fromHost);
    if (fromHost) begin
      hostAck <= 1'b1;
    end else begin
      rxPacketAcked <= 1'b1;
    end
    @(posedge sys_clk);
    hostAck <= 1'b0;
    rxPacketAcked <= 1'b0;
    @(posedge sys_clk);
  endtask
  // bus activity pin and suspend level, held until changed again
  task automatic bus_state(input logic act, input logic susp);
    busActivity <= act;
    suspended <= susp;
    @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

/* bench/usb_endpoint_tx_control_tb.sv */
// self-checking bench for the endpoint transmit control block
// assumes the host model drives the token port and software acts over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module usb_endpoint_tx_control_tb
  import usb_ep_ctrl_pkg::*;
;
  logic sys_clk, rst_b, clkEn;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic tokenValid, txByteReq, txLast, hostAck, rxPacketAcked, busActivity, suspended;
  logic resumeDriveK, resumeDriveEn;
  token_type tokenKind;
  answer_type tokenAnswer;
  logic [3:0] tokenEndpoint, txPid, txByteCount;
  logic [7:0] txByte;
  int errCount, testsRun;

  usb_endpoint_tx_control i_dut (
    .sys_clk, .rst_b, .clkEn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .tokenValid, .tokenKind, .tokenEndpoint, .tokenAnswer, .txPid, .txByteCount,
    .txByteReq, .txByte, .txLast, .hostAck, .rxPacketAcked, .busActivity, .suspended,
    .resumeDriveK, .resumeDriveEn
  );
  usb_host_model i_host (
    .sys_clk, .tokenAnswer, .txByte, .tokenValid, .tokenKind, .tokenEndpoint, .txByteReq,
    .hostAck, .rxPacketAcked, .busActivity, .suspended
  );

  // 20 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic hang;
    errCount++;
    tally_and_finish();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      errCount++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] fb(input int b);
    return 8'h01 << b;
  endfunction

  // bus write: address and data offered together, each released once taken
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (s_axi_bvalid !== 1'b1) hang();
    @(posedge sys_clk);
  endtask
  // bus read: address held until taken, data taken with rvalid
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (s_axi_rvalid !== 1'b1) hang();
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(d, {24'h0, e});
  endtask
  task automatic tok(input token_type k, input logic [3:0] ep, input answer_type e);
    answer_type a;
    i_host.token(k, ep, a);
    chk(32'(a), 32'(e));
  endtask

  // reset values, byte count field, unmapped address
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rd(CTRL_TX_CONTROL_ADDR, 8'h00);
    rd(SHARED_TX_CONTROL_ADDR, 8'h00);
    wr(CTRL_TX_CONTROL_ADDR, 8'h0F);
    rd(CTRL_TX_CONTROL_ADDR, 8'h0F);
    axi_rd(12'h004, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
  endtask
  // control IN with both data PIDs, done flag after ack, NAK when done or disabled
  task automatic t_ctrl_in;
    logic [7:0] b;
    for (int s = 0; s < 2; s++) begin
      wr(CTRL_TX_CONTROL_ADDR, {s[0], 3'h2, 4'h3});
      for (int i = 0; i < 3; i++) wr(CTRL_TX_DATA_ADDR, 8'(8'h51 + 3 * s + i));
      tok(TOK_IN, 4'h0, ANS_DATA);
      chk(32'(txPid), 32'(s ? PID_DATA1 : PID_DATA0));
      chk(32'(txByteCount), 32'h3);
      for (int i = 0; i < 3; i++) begin
        chk(32'(txLast), 32'(i == 2));
        i_host.fetch(b);
        chk(32'(b), 32'(8'h51 + 3 * s + i));
      end
      rd(FLAG_STATUS_ADDR, 8'h00);
      i_host.handshake(1'b1);
      rd(FLAG_STATUS_ADDR, fb(CTRL_TXD_BIT));
      tok(TOK_IN, 4'h0, ANS_NAK);
      wr(FLAG_STATUS_ADDR, fb(CTRL_TXD_BIT));
    end
    wr(CTRL_TX_CONTROL_ADDR, 8'h03);
    tok(TOK_IN, 4'h0, ANS_NAK);
  endtask
  // control OUT: NAK when disabled or receive done set
  task automatic t_ctrl_out;
    tok(TOK_OUT, 4'h0, ANS_NAK);
    wr(CTRL_TX_CONTROL_ADDR, 8'h10);
    tok(TOK_OUT, 4'h0, ANS_ACCEPT);
    i_host.handshake(1'b0);
    rd(FLAG_STATUS_ADDR, fb(CTRL_RXD_BIT));
    tok(TOK_OUT, 4'h0, ANS_NAK);
    wr(FLAG_STATUS_ADDR, fb(CTRL_RXD_BIT));
    tok(TOK_OUT, 4'h0, ANS_ACCEPT);
    wr(CTRL_TX_CONTROL_ADDR, 8'h00);
  endtask
  // stall beats enables, and a setup token clears it
  task automatic t_stall;
    answer_type a;
    wr(CTRL_TX_CONTROL_ADDR, 8'h70);
    tok(TOK_IN, 4'h0, ANS_STALL);
    tok(TOK_OUT, 4'h0, ANS_STALL);
    i_host.token(TOK_SETUP, 4'h0, a);
    rd(CTRL_TX_CONTROL_ADDR, 8'h30);
    wr(CTRL_TX_CONTROL_ADDR, 8'h00);
  endtask
  // shared buffer: select, PID, done and enable gating, endpoint 2 stall
  task automatic t_shared;
    logic [7:0] b;
    wr(ENDPOINT_ENABLE_ADDR, 8'h0C);
    wr(SHARED_TX_CONTROL_ADDR, 8'h22);
    wr(SHARED_TX_DATA_ADDR, 8'hC0);
    wr(SHARED_TX_DATA_ADDR, 8'hC1);
    tok(TOK_IN, 4'h2, ANS_NAK);
    tok(TOK_IN, 4'h1, ANS_DATA);
    chk(32'(txPid), 32'(PID_DATA0));
    chk(32'(txByteCount), 32'h2);
    for (int i = 0; i < 2; i++) begin
      i_host.fetch(b);
      chk(32'(b), 32'(8'hC0 + i));
    end
    i_host.handshake(1'b1);
    tok(TOK_IN, 4'h1, ANS_NAK);
    wr(FLAG_STATUS_ADDR, fb(SHARED_TXD_BIT));
    wr(SHARED_TX_CONTROL_ADDR, 8'hE1);
    wr(SHARED_TX_DATA_ADDR, 8'hC2);
    tok(TOK_IN, 4'h2, ANS_DATA);
    chk(32'(txPid), 32'(PID_DATA1));
    i_host.fetch(b);
    chk(32'(b), 32'hC2);
    wr(SHARED_TX_CONTROL_ADDR, 8'hC1);
    tok(TOK_IN, 4'h2, ANS_NAK);
    wr(ENDPOINT_ENABLE_ADDR, 8'h0E);
    wr(SHARED_TX_CONTROL_ADDR, 8'hE1);
    tok(TOK_IN, 4'h2, ANS_STALL);
    wr(SHARED_TX_CONTROL_ADDR, 8'h00);
  endtask
  // forced resume drives K and hides suspended bus activity from the resume flag; held briefly to keep the run short
  task automatic t_resume;
    wr(SHARED_TX_CONTROL_ADDR, 8'h10);
    i_host.bus_state(1'b1, 1'b1);
    repeat (3) @(posedge sys_clk);
    chk(32'({resumeDriveK, resumeDriveEn}), 32'h3);
    rd(FLAG_STATUS_ADDR, 8'h00);
    wr(SHARED_TX_CONTROL_ADDR, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk(32'({resumeDriveK, resumeDriveEn}), 32'h0);
    rd(FLAG_STATUS_ADDR, fb(RESUMED_BIT));
  endtask

  // reset, then the scenarios in turn
  initial begin
    errCount = 0;
    testsRun = 0;
    clkEn = 1'b1;
    rst_b = 1'b0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    t_regs();
    t_ctrl_in();
    t_ctrl_out();
    t_stall();
    t_shared();
    t_resume();
    tally_and_finish();
  end
endmodule
`default_nettype wire
